// >>> shared/uart_rx_consts.svh
`ifndef UART_RX_CONSTS_SVH
`define UART_RX_CONSTS_SVH
// APB byte offsets
`define OFF_CTRL_ONE    12'h000
`define OFF_CTRL_TWO    12'h004
`define OFF_STATUS_ONE  12'h008
`define OFF_DATA        12'h00C
`define OFF_IRQ_STATUS  12'h010
`define OFF_IRQ_ENABLE  12'h014
`define OFF_IRQ_CLEAR   12'h018
`define OFF_BAUD_DIV    12'h01C
// Control register one fields
`define C1_NINE_BIT     0
`define C1_ADDR_WAKE    1
`define C1_QUIET_ORIGIN 2
`define C1_ENABLE       3
// Control register two fields
`define C2_STANDBY      0
// Interrupt status fields
`define IRQ_FULL        0
`define IRQ_IDLE        1
`define IRQ_NOISE       2
`define IRQ_FRAME       3
`define IRQ_W           4
// Sampling positions and counts
`define TICKS_PER_BIT   5'd16
`define POS_START_A     5'd3
`define POS_START_B     5'd5
`define POS_START_C     5'd7
`define POS_VOTE_A      5'd8
`define POS_VOTE_B      5'd9
`define POS_VOTE_C      5'd10
`define POS_FIRST       5'd1
`define POS_RESYNC      5'd2
`define HUNT_ONES       2'd3
`define DATA_BITS_8     4'd8
`define DATA_BITS_9     4'd9
`define QUIET_BITS_8    4'd10
`define QUIET_BITS_9    4'd11
`define BAUD_DIV_RESET  16'h000A
`endif

// >>> shared/uart_rx_pkg.sv
package uart_rx_pkg;
	// Receiver states
	typedef enum logic [1:0] {
		ST_HUNT,
		ST_START,
		ST_DATA,
		ST_STOP
	} rx_state_t;
	// Per-character result flags
	typedef struct packed {
		logic noise;
		logic frame;
	} rx_err_t;
endpackage : uart_rx_pkg

// >>> verilog/uart_rx_sampling_wakeup.sv
`include "uart_rx_consts.svh"

module uart_rx_sampling_wakeup (
	// APB
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// Serial line and interrupt
	input  wire logic        rx_pin,
	output logic             irq
);
	// Pin synchroniser and registers
	logic [2:0]  sync_ff, nxt_sync;
	logic        line_ff, nxt_line;
	logic [15:0] div_ff, nxt_div, div_cnt_ff, nxt_div_cnt;
	logic [3:0]  c1_ff, nxt_c1;
	logic        standby_request_ff, nxt_standby;
	logic [8:0]  data_ff, nxt_data;
	logic        ninth_rx_bit_ff, nxt_ninth;
	logic        rx_full_flag_ff, nxt_full;
	logic        idle_ff, nxt_idle;
	logic        noise_flag_ff, nxt_noise_flag;
	logic        framing_error_ff, nxt_frame;
	logic [3:0]  ist_ff, nxt_ist, ien_ff, nxt_ien;
	logic [31:0] prdata_ff, nxt_prdata;
	logic        pready_ff, nxt_pready, pslverr_ff, nxt_pslverr;
	logic        irq_ff, nxt_irq;
	// Receiver engine state
	uart_rx_pkg::rx_state_t state_ff, nxt_state;
	logic [4:0]  oversample_tick_ff, nxt_tick;
	logic [1:0]  ones_ff, nxt_ones;
	logic [2:0]  vote_ff, nxt_vote;
	logic [3:0]  bit_ff, nxt_bit;
	logic [8:0]  shift_ff, nxt_shift;
	logic        prev_bit_ff, nxt_prev_bit;
	logic        acc_noise_ff, nxt_acc_noise;
	logic [3:0]  quiet_ff, nxt_quiet;
	logic        quiet_done_ff, nxt_quiet_done;
	// Combinational helpers
	logic        tick, wr, rd, maj, even, start_hi2, bit_done;
	logic        ev_full, ev_idle;
	uart_rx_pkg::rx_err_t err;
	logic [3:0]  nbits, qbits;

	assign prdata  = prdata_ff;
	assign pready  = pready_ff;
	assign pslverr = pslverr_ff;
	assign irq     = irq_ff;
	assign wr = psel && penable && pwrite && !pready_ff;
	assign rd = psel && penable && !pwrite && !pready_ff;

	// Three-stage pin synchroniser; stages two and three must agree
	always_comb begin
		nxt_sync = {sync_ff[1:0], rx_pin};
		nxt_line = (sync_ff[2] == sync_ff[1]) ? sync_ff[2] : line_ff;
	end

	// Oversample tick divider from pclk
	always_comb begin
		tick = c1_ff[`C1_ENABLE] && (div_cnt_ff == 16'h0000);
		nxt_div_cnt = tick ? div_ff : (div_cnt_ff - 16'h0001);
		if (!c1_ff[`C1_ENABLE]) nxt_div_cnt = div_ff;
	end

	// Receiver engine, one step per oversample tick
	always_comb begin
		nxt_state = state_ff;
		nxt_tick = oversample_tick_ff;
		nxt_ones = ones_ff;
		nxt_vote = vote_ff;
		nxt_bit = bit_ff;
		nxt_shift = shift_ff;
		nxt_prev_bit = prev_bit_ff;
		nxt_acc_noise = acc_noise_ff;
		nxt_quiet = quiet_ff;
		nxt_quiet_done = quiet_done_ff;
		ev_full = 1'b0;
		ev_idle = 1'b0;
		err = '0;
		nbits = c1_ff[`C1_NINE_BIT] ? `DATA_BITS_9 : `DATA_BITS_8;
		qbits = c1_ff[`C1_NINE_BIT] ? `QUIET_BITS_9 : `QUIET_BITS_8;
		// Votes: vote_ff[1] and vote_ff[0] hold the two earlier samples
		maj = (vote_ff[1] & vote_ff[0]) | (vote_ff[1] & line_ff)
			| (vote_ff[0] & line_ff);
		// Unanimous only when both earlier samples match the third
		even = (vote_ff[1:0] == {2{line_ff}});
		start_hi2 = (vote_ff[1] & vote_ff[0]) | (vote_ff[1] & line_ff)
			| (vote_ff[0] & line_ff);
		bit_done = (oversample_tick_ff == `TICKS_PER_BIT);
		if (tick) begin
			// Count sample positions 1..16 within a bit
			nxt_tick = bit_done ? `POS_FIRST : (oversample_tick_ff + 5'd1);
			// Count consecutive high bits for quiet line
			// Skipped in the start bit and at a hunt low sample
			if (bit_done && state_ff != uart_rx_pkg::ST_START
				&& !(state_ff == uart_rx_pkg::ST_HUNT && !line_ff)) begin
				if (!line_ff) begin
					nxt_quiet = 4'd0;
				end else if (quiet_ff != qbits) begin
					nxt_quiet = quiet_ff + 4'd1;
					if (quiet_ff + 4'd1 == qbits && !quiet_done_ff) begin
						ev_idle = 1'b1;
						nxt_quiet_done = 1'b1;
					end
				end
			end
			unique case (state_ff)
				// Waiting for a falling edge after an idle run
				uart_rx_pkg::ST_HUNT: begin
					// Zero after three ones begins a start bit
					if (line_ff) begin
						if (ones_ff != `HUNT_ONES) nxt_ones = ones_ff + 2'd1;
					end else if (ones_ff == `HUNT_ONES) begin
						nxt_state = uart_rx_pkg::ST_START;
						// The low sample was position one
						nxt_tick = `POS_RESYNC;
						nxt_vote = 3'b000;
						nxt_acc_noise = 1'b0;
						nxt_quiet_done = 1'b0;
						// After-start origin clears count here
						if (!c1_ff[`C1_QUIET_ORIGIN]) nxt_quiet = 4'd0;
					end else begin
						nxt_ones = 2'd0;
					end
					// A low without three ones restarts the bit count
					if (!line_ff && ones_ff != `HUNT_ONES)
						nxt_tick = `POS_FIRST;
				end
				// Checking the start bit, counting its sixteen samples
				uart_rx_pkg::ST_START: begin
					if (oversample_tick_ff == `POS_START_A
						|| oversample_tick_ff == `POS_START_B)
						nxt_vote = {vote_ff[1:0], line_ff};
					if (oversample_tick_ff == `POS_START_C) begin
						// Verify start, at most one high sample
						if (start_hi2) begin
							// Two or more highs: false start, hunt again
							nxt_state = uart_rx_pkg::ST_HUNT;
							nxt_ones = 2'd0;
							nxt_tick = `POS_FIRST;
						end else if (vote_ff[1] | vote_ff[0] | line_ff) begin
							nxt_acc_noise = 1'b1;
						end
					end
					if (oversample_tick_ff >= `POS_VOTE_A
						&& oversample_tick_ff <= `POS_VOTE_C && line_ff)
						nxt_acc_noise = 1'b1;
					if (bit_done) begin
						// Start bit ends, counter wraps to position one
						nxt_state = uart_rx_pkg::ST_DATA;
						// First data bit follows a zero start bit
						nxt_bit = 4'd0;
						nxt_prev_bit = 1'b0;
					end
				end
				// Data and stop bits share the vote at 8, 9 and 10
				uart_rx_pkg::ST_DATA, uart_rx_pkg::ST_STOP: begin
					if (oversample_tick_ff == `POS_VOTE_A
						|| oversample_tick_ff == `POS_VOTE_B)
						nxt_vote = {vote_ff[1:0], line_ff};
					if (oversample_tick_ff == `POS_VOTE_C) begin
						if (!even) nxt_acc_noise = 1'b1;
						if (state_ff == uart_rx_pkg::ST_DATA) begin
							// Majority vote for data bit, LSB first
							nxt_shift = {maj, shift_ff[8:1]};
							nxt_prev_bit = maj;
							nxt_bit = bit_ff + 4'd1;
							// Last data bit hands over to the stop bit
							if (bit_ff + 4'd1 == nbits)
								nxt_state = uart_rx_pkg::ST_STOP;
						end else begin
							// Stop at 9 or 10 bit times + 10 ticks
							err.frame = !maj;
							err.noise = acc_noise_ff | !even;
							ev_full = 1'b1;
							// A high stop counts toward the next hunt
							nxt_state = uart_rx_pkg::ST_HUNT;
							nxt_ones = maj ? `HUNT_ONES : 2'd0;
							// After-stop origin starts count here
							if (c1_ff[`C1_QUIET_ORIGIN]) nxt_quiet = 4'd0;
						end
					end
					// Valid falling edge within data resyncs
					// Only after the vote, so a mid-bit glitch cannot move it
					if (state_ff == uart_rx_pkg::ST_DATA && prev_bit_ff
						&& !line_ff && oversample_tick_ff > `POS_VOTE_C)
						nxt_tick = `POS_RESYNC;
				end
			endcase
		end
		// A disabled receiver drops any half-received character
		if (!c1_ff[`C1_ENABLE]) begin
			nxt_state = uart_rx_pkg::ST_HUNT;
			nxt_ones = 2'd0;
			nxt_tick = `POS_FIRST;
		end
	end

	// Status, data buffer, standby and APB register side
	always_comb begin
		nxt_c1 = c1_ff;
		nxt_div = div_ff;
		nxt_standby = standby_request_ff;
		nxt_data = data_ff;
		nxt_ninth = ninth_rx_bit_ff;
		nxt_full = rx_full_flag_ff;
		nxt_idle = idle_ff;
		nxt_noise_flag = noise_flag_ff;
		nxt_frame = framing_error_ff;
		nxt_ien = ien_ff;
		nxt_ist = ist_ff;
		nxt_prdata = 32'h0000_0000;
		nxt_pslverr = 1'b0;
		// One wait state: ready answers the first access cycle
		nxt_pready = psel && penable && !pready_ff;
		// Reading the data word clears receive-side flags
		if (rd && paddr == `OFF_DATA) begin
			nxt_full = 1'b0;
			nxt_idle = 1'b0;
			nxt_noise_flag = 1'b0;
			nxt_frame = 1'b0;
		end
		// Register writes, taken in the first access cycle
		if (wr) begin
			unique case (paddr)
				`OFF_CTRL_ONE:   nxt_c1 = pwdata[3:0];
				`OFF_CTRL_TWO:   nxt_standby = pwdata[`C2_STANDBY];
				`OFF_IRQ_ENABLE: nxt_ien = pwdata[3:0];
				`OFF_IRQ_CLEAR:  nxt_ist = ist_ff & ~pwdata[3:0];
				`OFF_BAUD_DIV:   nxt_div = pwdata[15:0];
				default:         nxt_pslverr = (paddr != `OFF_IRQ_STATUS)
					&& (paddr != `OFF_STATUS_ONE) && (paddr != `OFF_DATA);
			endcase
		end
		// Read data registered for the cycle with pready
		if (rd) begin
			unique case (paddr)
				`OFF_CTRL_ONE:   nxt_prdata = {28'h0, c1_ff};
				`OFF_CTRL_TWO:   nxt_prdata = {31'h0, standby_request_ff};
				`OFF_STATUS_ONE: nxt_prdata = {27'h0, ninth_rx_bit_ff,
					framing_error_ff, noise_flag_ff, idle_ff,
					rx_full_flag_ff};
				`OFF_DATA:       nxt_prdata = {24'h0, data_ff[7:0]};
				`OFF_IRQ_STATUS: nxt_prdata = {28'h0, ist_ff};
				`OFF_IRQ_ENABLE: nxt_prdata = {28'h0, ien_ff};
				`OFF_BAUD_DIV:   nxt_prdata = {16'h0, div_ff};
				default:         nxt_pslverr = (paddr != `OFF_IRQ_CLEAR);
			endcase
		end
		// Character completion; hardware set wins over clears
		if (ev_full) begin
			// The character MSB lands in bit 8 for both lengths
			if (standby_request_ff && c1_ff[`C1_ADDR_WAKE]
				&& shift_ff[8]) begin
				nxt_standby = 1'b0;
			end
			if (!standby_request_ff || (c1_ff[`C1_ADDR_WAKE]
				&& shift_ff[8])) begin
				nxt_data = c1_ff[`C1_NINE_BIT] ? shift_ff
					: {1'b0, shift_ff[8:1]};
				// Ninth bit or copy of bit seven
				nxt_ninth = shift_ff[8];
				nxt_full = 1'b1;
				nxt_frame = err.frame;
				nxt_noise_flag = err.noise;
				nxt_ist[`IRQ_FULL] = 1'b1;
				if (err.noise) nxt_ist[`IRQ_NOISE] = 1'b1;
				if (err.frame) nxt_ist[`IRQ_FRAME] = 1'b1;
			end
		end
		// Idle character, or wake without flags
		if (ev_idle || (line_ff && quiet_done_ff && wr
			&& paddr == `OFF_CTRL_TWO)) begin
			if (!c1_ff[`C1_ADDR_WAKE] && (standby_request_ff
				|| (wr && paddr == `OFF_CTRL_TWO))) begin
				nxt_standby = 1'b0;
			end else if (ev_idle && !standby_request_ff) begin
				nxt_idle = 1'b1;
				nxt_ist[`IRQ_IDLE] = 1'b1;
			end
		end
		// Interrupt suppressed during standby
		nxt_irq = !nxt_standby && ((nxt_ist & nxt_ien) != 4'h0);
	end

	// Register all state
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync_ff <= 3'h7;
			line_ff <= 1'b1;
			div_ff <= `BAUD_DIV_RESET;
			div_cnt_ff <= 16'h0000;
			c1_ff <= 4'h0;
			standby_request_ff <= 1'b0;
			data_ff <= 9'h000;
			ninth_rx_bit_ff <= 1'b0;
			rx_full_flag_ff <= 1'b0;
			idle_ff <= 1'b0;
			noise_flag_ff <= 1'b0;
			framing_error_ff <= 1'b0;
			ist_ff <= 4'h0;
			ien_ff <= 4'h0;
			prdata_ff <= 32'h0000_0000;
			pready_ff <= 1'b0;
			pslverr_ff <= 1'b0;
			irq_ff <= 1'b0;
			state_ff <= uart_rx_pkg::ST_HUNT;
			oversample_tick_ff <= `POS_FIRST;
			ones_ff <= 2'd0;
			vote_ff <= 3'h0;
			bit_ff <= 4'h0;
			shift_ff <= 9'h000;
			prev_bit_ff <= 1'b0;
			acc_noise_ff <= 1'b0;
			quiet_ff <= 4'h0;
			quiet_done_ff <= 1'b0;
		end else begin
			sync_ff <= nxt_sync;
			line_ff <= nxt_line;
			div_ff <= nxt_div;
			div_cnt_ff <= nxt_div_cnt;
			c1_ff <= nxt_c1;
			standby_request_ff <= nxt_standby;
			data_ff <= nxt_data;
			ninth_rx_bit_ff <= nxt_ninth;
			rx_full_flag_ff <= nxt_full;
			idle_ff <= nxt_idle;
			noise_flag_ff <= nxt_noise_flag;
			framing_error_ff <= nxt_frame;
			ist_ff <= nxt_ist;
			ien_ff <= nxt_ien;
			prdata_ff <= nxt_prdata;
			pready_ff <= nxt_pready;
			pslverr_ff <= nxt_pslverr;
			irq_ff <= nxt_irq;
			state_ff <= nxt_state;
			oversample_tick_ff <= nxt_tick;
			ones_ff <= nxt_ones;
			vote_ff <= nxt_vote;
			bit_ff <= nxt_bit;
			shift_ff <= nxt_shift;
			prev_bit_ff <= nxt_prev_bit;
			acc_noise_ff <= nxt_acc_noise;
			quiet_ff <= nxt_quiet;
			quiet_done_ff <= nxt_quiet_done;
		end
	end
endmodule : uart_rx_sampling_wakeup

// >>> sim/uart_rx_sampling_wakeup_chk.sv
module uart_rx_sampling_wakeup_chk (
	// APB
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	// Line and interrupt
	input wire logic        rx_pin,
	input wire logic        irq
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic mask_ff;  // All interrupt enables are off
	logic nxt_mask;
	// Follow enable writes at the edge the design takes them
	always_comb begin
		nxt_mask = mask_ff;
		if (psel && penable && !pready && pwrite && paddr == 12'h014)
			nxt_mask = (pwdata[3:0] == 4'h0);
	end
	// Enables are off after reset
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			mask_ff <= 1'b1;
		else
			mask_ff <= nxt_mask;
	end
	a_one_wait: assert property (psel && penable && !pready |=> pready)
		else $error("answer not after one wait state");
	a_ready_pulse: assert property (pready |=> !pready)
		else $error("ready longer than one cycle");
	a_no_stray: assert property (!(psel && penable) |=> !pready)
		else $error("ready without access phase");
	a_err_qual: assert property (pslverr |-> pready)
		else $error("error without ready");
	a_unmapped_err: assert property (psel && penable && !pready &&
		paddr > 12'h01C |=> pslverr)
		else $error("unmapped access not refused");
	a_mapped_ok: assert property (psel && penable && !pready &&
		paddr <= 12'h01C && paddr[1:0] == 2'b00 |=> !pslverr)
		else $error("mapped access refused");
	a_upper_zero: assert property (pready && !pwrite |->
		prdata[31:16] == 16'h0000)
		else $error("unused read bits not zero");
	a_irq_masked: assert property (mask_ff && $past(mask_ff) |-> !irq)
		else $error("interrupt while all enables off");
endmodule : uart_rx_sampling_wakeup_chk

bind uart_rx_sampling_wakeup uart_rx_sampling_wakeup_chk i_chk (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .rx_pin(rx_pin), .irq(irq)
);

// >>> sim/uart_line_tx.sv
module uart_line_tx #(
	parameter int TICK = 2  // Clocks per oversample tick
) (
	// Request
	input  wire logic       pclk,
	input  wire logic       go,
	input  wire logic [8:0] data,
	input  wire logic       nine,
	input  wire logic       stop_bit,
	input  wire logic [3:0] glitch_at,
	// Line
	output logic            rx_pin,
	output logic            busy
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [10:0] frm;  // Start, data LSB first, stop
	int          n;    // Bits in frame
	// One frame per request, one-tick glitch mid bit, idle high
	initial begin
		rx_pin = 1'b1;
		busy   = 1'b0;
		forever begin
			@(posedge pclk);
			if (go) begin
				busy <= 1'b1;
				frm = nine ? {stop_bit, data, 1'b0}
					: {1'b1, stop_bit, data[7:0], 1'b0};
				n = nine ? 11 : 10;
				for (int b = 0; b < n; b++)
					for (int c = 0; c < 16 * TICK; c++) begin
						rx_pin <= frm[b] ^ (b == glitch_at && c / TICK == 8);
						@(posedge pclk);
					end
				rx_pin <= 1'b1;
				busy   <= 1'b0;
			end
		end
	end
endmodule : uart_line_tx

// >>> sim/uart_rx_sampling_wakeup_bench.sv
`include "uart_rx_consts.svh"
module uart_rx_sampling_wakeup_bench;
	timeunit 1ns;
	timeprecision 1ns;
	`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin \
		miscompares++; $display("wrong value at %0t: %h", $time, g); end end
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic        rx_pin, irq, busy, go, nine, stop_bit, err;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, q;
	logic [8:0]  data, d;
	logic [3:0]  glitch_at, g;
	int          miscompares, comparisons, seed;
	logic [8:0]  expq[$];  // Characters the line model sent
	uart_rx_sampling_wakeup i_uart_rx_sampling_wakeup (.pclk(pclk),
		.presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .rx_pin(rx_pin), .irq(irq));
	uart_line_tx #(.TICK(2)) i_uart_line_tx (.pclk(pclk), .go(go),
		.data(data), .nine(nine), .stop_bit(stop_bit),
		.glitch_at(glitch_at), .rx_pin(rx_pin), .busy(busy));
	// Clock of 40 ns
	initial begin
		pclk = 1'b0;
		forever #20 pclk = ~pclk;
	end
	// Verdict and end of run
	task automatic conclude;
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : conclude
	// One APB transfer, held until ready
	task automatic apb(input logic wr, input logic [11:0] a,
		input logic [31:0] w);
		int n;
		@(posedge pclk);
		psel   <= 1'b1;
		pwrite <= wr;
		paddr  <= a;
		pwdata <= w;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		if (n >= 16) begin
			miscompares++;
			conclude();
		end
		q = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	// Hand a frame to the line model, wait till it is sent
	task automatic send(input logic [8:0] c, input logic s,
		input logic [3:0] x);
		int n;
		@(posedge pclk);
		data      <= c;
		stop_bit  <= s;
		glitch_at <= x;
		go        <= 1'b1;
		@(posedge pclk);
		go <= 1'b0;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (busy !== 1'b0 && n < 2000);
		if (n >= 2000) begin
			miscompares++;
			conclude();
		end
	endtask : send
	// Status and data of the oldest character
	task automatic chk_char(input logic nz, input logic fe);
		logic [8:0] e;
		e = expq.pop_front();
		apb(1'b0, `OFF_STATUS_ONE, 32'h0);
		`CHK(q & 32'h1D, {27'h0, nine ? e[8] : e[7], fe, nz, 2'b01})
		apb(1'b0, `OFF_DATA, 32'h0);
		`CHK(q[7:0], e[7:0])
	endtask : chk_char
	// Main sequence
	initial begin
		{psel, penable, pwrite, go, nine, presetn} = 6'h00;
		{paddr, pwdata, data, stop_bit, glitch_at} = '0;
		{miscompares, comparisons, seed} = {32'h0, 32'h0, 32'h5989};
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b1, `OFF_BAUD_DIV, 32'h1);
		for (int i = 0; i < 6; i++) begin
			nine <= i[0];
			apb(1'b1, `OFF_CTRL_ONE, {28'h0, 3'b100, i[0]});
			d = 9'($random(seed));
			g = i < 2 ? 4'hF : 4'((32'($random(seed)) & 32'hFF) % (10 + i[0]));
			expq.push_back(d);
			send(d, 1'b1, g);
			chk_char(g != 4'hF, 1'b0);
			$display("character test %0d done", i);
		end
		nine <= 1'b0;
		apb(1'b1, `OFF_CTRL_ONE, 32'h8);
		expq.push_back(9'h000);
		send(9'h000, 1'b0, 4'hF);
		chk_char(1'b0, 1'b1);
		apb(1'b1, `OFF_IRQ_CLEAR, 32'hF);
		apb(1'b1, `OFF_IRQ_ENABLE, 32'h1);
		`CHK(irq, 1'b0)
		expq.push_back(9'h05A);
		send(9'h05A, 1'b1, 4'hF);
		`CHK(irq, 1'b1)
		chk_char(1'b0, 1'b0);
		$display("break and interrupt test done");
		apb(1'b1, `OFF_CTRL_ONE, 32'hA);
		apb(1'b1, `OFF_CTRL_TWO, 32'h1);
		`CHK(irq, 1'b0)
		apb(1'b0, `OFF_CTRL_TWO, 32'h0);
		`CHK(q[0], 1'b1)
		apb(1'b1, `OFF_IRQ_CLEAR, 32'h1);
		apb(1'b0, 12'h020, 32'h0);
		`CHK({err, irq}, 2'b10)
		send(9'h012, 1'b1, 4'hF);
		apb(1'b0, `OFF_STATUS_ONE, 32'h0);
		`CHK({q[0], irq}, 2'b00)
		d = 9'h080 | 9'($random(seed));
		expq.push_back(d);
		send(d, 1'b1, 4'hF);
		`CHK(irq, 1'b1)
		apb(1'b0, `OFF_CTRL_TWO, 32'h0);
		`CHK(q[0], 1'b0)
		chk_char(1'b0, 1'b0);
		apb(1'b1, `OFF_CTRL_ONE, 32'h8);
		apb(1'b1, `OFF_CTRL_TWO, 32'h1);
		apb(1'b0, `OFF_CTRL_TWO, 32'h0);
		`CHK(q[0], 1'b1)
		repeat (400) @(posedge pclk);
		apb(1'b0, `OFF_CTRL_TWO, 32'h0);
		`CHK(q[0], 1'b0)
		apb(1'b0, `OFF_STATUS_ONE, 32'h0);
		`CHK(q[1:0], 2'b00)
		apb(1'b1, `OFF_CTRL_TWO, 32'h1);
		apb(1'b0, `OFF_CTRL_TWO, 32'h0);
		`CHK(q[0], 1'b0)
		$display("wakeup test done");
		conclude();
	end
endmodule : uart_rx_sampling_wakeup_bench
